/* mcl_pkg.sv */
// package for the modem control and loop-back block: offsets, field positions,
// reset values and the vector types shared by the block and its helpers.
// assumes a 32-bit apb with byte addresses; only the low address byte is decoded.
package mcl_pkg;

   // ---------------------------------------------------------------
   // register offsets (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam int unsigned MCL_AW = 8;
   localparam logic [7:0] MCL_OFF_MODEM_CTRL = 8'h00;
   localparam logic [7:0] MCL_OFF_MODEM_STAT = 8'h04;
   localparam logic [7:0] MCL_OFF_IRQ_STATUS = 8'h08;
   localparam logic [7:0] MCL_OFF_IRQ_ENABLE = 8'h0c;
   localparam logic [7:0] MCL_OFF_IRQ_CLEAR = 8'h10;

   // ---------------------------------------------------------------
   // modem_control fields and reset value
   // ---------------------------------------------------------------
   localparam int unsigned MCL_MC_DTR = 0;
   localparam int unsigned MCL_MC_RTS = 1;
   localparam int unsigned MCL_MC_AUX_A = 2;
   localparam int unsigned MCL_MC_AUX_B = 3;
   localparam int unsigned MCL_MC_LOOP = 4;
   localparam logic [7:0] MCL_MC_RESET = 8'h00;
   localparam logic [7:0] MCL_MC_WMASK = 8'h1f;

   // ---------------------------------------------------------------
   // modem status and interrupt vector layout
   // ---------------------------------------------------------------
   localparam int unsigned MCL_MS_W = 4;
   localparam int unsigned MCL_MS_CTS = 0;
   localparam int unsigned MCL_MS_DSR = 1;
   localparam int unsigned MCL_MS_RI = 2;
   localparam int unsigned MCL_MS_DCD = 3;
   localparam int unsigned MCL_IRQ_W = 6;
   localparam int unsigned MCL_IRQ_RX = 4;
   localparam int unsigned MCL_IRQ_TX = 5;
   localparam logic [5:0] MCL_IRQ_EN_RESET = 6'h00;
   localparam logic MCL_MARK_LEVEL = 1'b1;

   typedef logic [MCL_MS_W-1:0] mcl_ms_vec_t;
   typedef logic [MCL_IRQ_W-1:0] mcl_irq_vec_t;

endpackage

/* mcl_evt_if.sv */
// interface carrying modem levels, events and interrupt state between the
// top of the modem control block and its two helpers; all on sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
interface mcl_evt_if;
   mcl_pkg::mcl_ms_vec_t modem_now;
   mcl_pkg::mcl_ms_vec_t modem_evt;
   logic [1:0] core_evt;
   mcl_pkg::mcl_irq_vec_t irq_status;
   mcl_pkg::mcl_irq_vec_t irq_en;
   mcl_pkg::mcl_irq_vec_t clr_mask;
   logic clr_stb;
   logic irq_line;

   modport top (output modem_now, core_evt, irq_en, clr_mask, clr_stb,
                input modem_evt, irq_status, irq_line);
   modport det (input modem_now, output modem_evt);
   modport irq (input modem_evt, core_evt, irq_en, clr_mask, clr_stb,
                output irq_status, irq_line);
endinterface
`default_nettype wire

/* mcl_delta.sv */
// modem status change detector: one event pulse per change of a modem level; ring pulses only when a ring ends.
// assumes modem_now is already muxed between pins and loop-back sources.
`timescale 1ns/1ps
`default_nettype none
module mcl_delta (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   mcl_evt_if.det ev
);
   import mcl_pkg::*;

   mcl_ms_vec_t prev;

   // ---------------------------------------------------------------
   // per-line history and edge decode
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prev <= '0;
      end else begin
         prev <= ev.modem_now;
      end
   end

   // ring reports only the end of a ring, the others any change
   for (genvar i = 0; i < MCL_MS_W; i++) begin : g_line
      if (i == MCL_MS_RI) begin : g_trail
         assign ev.modem_evt[i] = prev[i] & ~ev.modem_now[i];
      end else begin : g_any
         assign ev.modem_evt[i] = prev[i] ^ ev.modem_now[i];
      end
   end
endmodule
`default_nettype wire

/* mcl_irq.sv */
// sticky interrupt status with enable gating and write-one-to-clear.
// assumes clr_stb is a one-cycle pulse with clr_mask valid beside it.
`timescale 1ns/1ps
`default_nettype none
module mcl_irq (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   mcl_evt_if.irq ev
);
   import mcl_pkg::*;

   mcl_irq_vec_t src;

   // ---------------------------------------------------------------
   // event sources and sticky bits
   // ---------------------------------------------------------------
   assign src = {ev.core_evt, ev.modem_evt};

   // a set in the clear cycle wins so no event is lost
   for (genvar i = 0; i < MCL_IRQ_W; i++) begin : g_bit
      always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
         if (!arst_n_in) begin
            ev.irq_status[i] <= 1'b0;
         end else if (src[i]) begin
            ev.irq_status[i] <= 1'b1;
         end else if (ev.clr_stb && ev.clr_mask[i]) begin
            ev.irq_status[i] <= 1'b0;
         end
      end
   end

   // enables gate every source, loop-back or not
   assign ev.irq_line = |(ev.irq_status & ev.irq_en);
endmodule
`default_nettype wire

/* mcl_top.sv */
// modem control register, local loop-back routing and interrupt pin control.
// assumes an apb master on sys_clk_in and pins already synchronous to it.
`timescale 1ns/1ps
`default_nettype none

module mcl_top (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic [mcl_pkg::MCL_AW-1:0] paddr_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic tx_serial_in,
   output logic tx_pin_out,
   input wire logic rx_pin_in,
   output logic rx_serial_out,
   input wire logic cts_n_in,
   input wire logic dsr_n_in,
   input wire logic dcd_n_in,
   input wire logic ri_n_in,
   output logic rts_n_out,
   output logic [mcl_pkg::MCL_MS_W-1:0] modem_status_out,
   input wire logic rx_event_in,
   input wire logic tx_event_in,
   output logic irq_out,
   output logic irq_oe_out
);
   import mcl_pkg::*;

   // ---------------------------------------------------------------
   // state and helpers
   // ---------------------------------------------------------------
   logic [7:0] modem_control;
   mcl_irq_vec_t irq_enable_reg;
   logic loop_on;
   logic setup_ph;
   logic wr_stb;
   logic [31:0] next_rdata;
   logic next_err;
   mcl_ms_vec_t pin_levels;
   mcl_ms_vec_t loop_levels;
   mcl_ms_vec_t next_modem;

   // one bundle carries levels, events and interrupt state to both helpers
   mcl_evt_if ev ();

   // ---------------------------------------------------------------
   // apb slave timing
   // ---------------------------------------------------------------
   // zero wait states: read data is staged in the setup cycle
   assign pready_out = 1'b1;
   assign setup_ph = psel_in & ~penable_in;
   assign wr_stb = psel_in & penable_in & pwrite_in;

   // writes to read-only words are dropped quietly; only unmapped words flag an error
   // read mux and address check, decided from the setup-phase address
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      if (paddr_in == MCL_OFF_MODEM_CTRL) begin
         next_rdata[7:0] = modem_control;
      end else if (paddr_in == MCL_OFF_MODEM_STAT) begin
         next_rdata[MCL_MS_W-1:0] = modem_status_out;
      end else if (paddr_in == MCL_OFF_IRQ_STATUS) begin
         next_rdata[MCL_IRQ_W-1:0] = ev.irq_status;
      end else if (paddr_in == MCL_OFF_IRQ_ENABLE) begin
         next_rdata[MCL_IRQ_W-1:0] = irq_enable_reg;
      end else if (paddr_in == MCL_OFF_IRQ_CLEAR) begin
         next_rdata = 32'h0000_0000; // write-only, reads zero
      end else begin
         next_err = 1'b1;
      end
   end

   // read data and error come from flops loaded in the setup cycle
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prdata_out <= 32'h0000_0000;
         pslverr_out <= 1'b0;
      end else if (setup_ph) begin
         prdata_out <= pwrite_in ? 32'h0000_0000 : next_rdata;
         pslverr_out <= next_err;
      end
   end

   // ---------------------------------------------------------------
   // modem_control register
   // ---------------------------------------------------------------
   // reserved bit 5 and the bits above store nothing and read zero,
   // so a careless write there cannot change any mode
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         modem_control <= MCL_MC_RESET;
      end else if (wr_stb && paddr_in == MCL_OFF_MODEM_CTRL) begin
         modem_control <= pwdata_in[7:0] & MCL_MC_WMASK;
      end
   end

   // every mux below keys on this one bit
   assign loop_on = modem_control[MCL_MC_LOOP];

   // ---------------------------------------------------------------
   // interrupt enable and clear registers
   // ---------------------------------------------------------------
   // enables only gate the pin; status bits keep collecting while masked
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_enable_reg <= MCL_IRQ_EN_RESET;
      end else if (wr_stb && paddr_in == MCL_OFF_IRQ_ENABLE) begin
         irq_enable_reg <= pwdata_in[MCL_IRQ_W-1:0];
      end
   end

   // a clear and a new event in one cycle leave the bit set, so nothing is lost
   // clear is a pulse in the access cycle; the sticky bits live in mcl_irq
   assign ev.clr_stb = wr_stb && paddr_in == MCL_OFF_IRQ_CLEAR;
   assign ev.clr_mask = pwdata_in[MCL_IRQ_W-1:0];
   assign ev.irq_en = irq_enable_reg;
   // core events bypass the loop mux entirely, so loop-back leaves them alone
   assign ev.core_evt = {tx_event_in, rx_event_in};

   // ---------------------------------------------------------------
   // modem input sources
   // ---------------------------------------------------------------
   // pins are active low; internal levels are active high
   assign pin_levels[MCL_MS_CTS] = ~cts_n_in;
   assign pin_levels[MCL_MS_DSR] = ~dsr_n_in;
   assign pin_levels[MCL_MS_RI] = ~ri_n_in;
   assign pin_levels[MCL_MS_DCD] = ~dcd_n_in;

   // loop-back takes the low four control bits in place of the pins
   assign loop_levels[MCL_MS_CTS] = modem_control[MCL_MC_RTS];
   assign loop_levels[MCL_MS_DSR] = modem_control[MCL_MC_DTR];
   assign loop_levels[MCL_MS_RI] = modem_control[MCL_MC_AUX_A];
   // bit 3 clear means carrier pin level high, i.e. inactive
   assign loop_levels[MCL_MS_DCD] = modem_control[MCL_MC_AUX_B];

   // the mux sits before the flop so a mode switch never glitches the core's levels
   assign next_modem = loop_on ? loop_levels : pin_levels;

   // one flop stage gives the core clean, registered modem levels
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         modem_status_out <= '0;
      end else begin
         modem_status_out <= next_modem;
      end
   end

   // change detection sees the registered levels, whichever source fed them
   assign ev.modem_now = modem_status_out;

   // ---------------------------------------------------------------
   // helpers: change detection and sticky interrupt status
   // ---------------------------------------------------------------
   // the delta helper sees levels only; the irq helper adds core events and masks
   mcl_delta u_delta (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .ev(ev.det)
   );

   mcl_irq u_irq (
      .sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in),
      .ev(ev.irq)
   );

   // ---------------------------------------------------------------
   // serial data routing
   // ---------------------------------------------------------------
   // the line sees only marking while looped, so a self test never
   // leaks frames to the peer; this costs one cycle of latency
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         tx_pin_out <= MCL_MARK_LEVEL;
         rx_serial_out <= MCL_MARK_LEVEL;
      end else if (loop_on) begin
         tx_pin_out <= MCL_MARK_LEVEL;
         rx_serial_out <= tx_serial_in;
      end else begin
         tx_pin_out <= tx_serial_in;
         rx_serial_out <= rx_pin_in;
      end
   end

   // ---------------------------------------------------------------
   // request-to-send and interrupt pin
   // ---------------------------------------------------------------
   // the rts pin follows bit 1 directly; automatic flow control is not here
   // in loop-back the pin keeps showing bit 1, so the peer sees no surprise
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rts_n_out <= 1'b1;
      end else begin
         rts_n_out <= ~modem_control[MCL_MC_RTS];
      end
   end

   // the enable is the pin's drive; with it low the board pull sets the level
   // irq_out carries the level even while floated; the pad gates it
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_out <= 1'b0;
         irq_oe_out <= 1'b0;
      end else begin
         irq_out <= ev.irq_line;
         irq_oe_out <= modem_control[MCL_MC_AUX_B];
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!arst_n_in);

   // ---------------------------------------------------------------
   // mode select and routing
   // ---------------------------------------------------------------
   // the mode bit follows the last write to the control word
   chk_mode_select:
   assert property (wr_stb && paddr_in == MCL_OFF_MODEM_CTRL |=> loop_on == $past(pwdata_in[MCL_MC_LOOP]))
      else $error("loop-back mode does not follow written bit 4");

   // no frame may leak to the line while looped
   chk_loop_tx_idle:
   assert property (loop_on ##1 loop_on |-> tx_pin_out == 1'b1)
      else $error("serial output pin not marking during loop-back");

   // the receiver hears the transmitter one cycle later
   chk_loop_rx_path:
   assert property (loop_on |=> rx_serial_out == $past(tx_serial_in))
      else $error("receiver input not looped from transmitter");

   // in normal mode serial data and cts come straight from the pins
   chk_norm_pins:
   assert property (!loop_on |=> modem_status_out[MCL_MS_CTS] == !$past(cts_n_in)
                    && rx_serial_out == $past(rx_pin_in) && tx_pin_out == $past(tx_serial_in))
      else $error("normal mode does not follow the pins");

   // all four modem levels follow their pins when not looped
   chk_norm_modem:
   assert property (!loop_on |=> modem_status_out ==
                    ~{$past(dcd_n_in), $past(ri_n_in), $past(dsr_n_in), $past(cts_n_in)})
      else $error("modem levels do not follow the pins in normal mode");

   // dsr takes the dtr bit while looped
   chk_loop_dsr_src:
   assert property (loop_on |=> modem_status_out[MCL_MS_DSR] == $past(modem_control[MCL_MC_DTR]))
      else $error("dsr not taken from bit 0 in loop-back");

   // ring indicate comes from the first auxiliary output
   chk_loop_ri_src:
   assert property (loop_on |=> modem_status_out[MCL_MS_RI] == $past(modem_control[MCL_MC_AUX_A]))
      else $error("ring indicate not taken from bit 2 in loop-back");

   // reserved bits store nothing, the low five store what was written
   chk_rsvd_bits:
   assert property (wr_stb && paddr_in == MCL_OFF_MODEM_CTRL |=> modem_control[7:5] == 3'h0
                    && modem_control[MCL_MC_LOOP:0] == $past(pwdata_in[MCL_MC_LOOP:0]))
      else $error("control word does not hold the written low bits");

   // ---------------------------------------------------------------
   // interrupt pin, carrier and request-to-send
   // ---------------------------------------------------------------
   // bit 3 clear: pin floated, carrier inactive
   chk_loop_dcd_src:
   assert property (loop_on && !modem_control[MCL_MC_AUX_B] |=> !modem_status_out[MCL_MS_DCD] && !irq_oe_out)
      else $error("bit 3 clear must float irq and deassert carrier in loop-back");

   // bit 3 set: pin driven, carrier active
   chk_loop_dcd_on:
   assert property (loop_on && modem_control[MCL_MC_AUX_B] |=> modem_status_out[MCL_MS_DCD] && irq_oe_out)
      else $error("bit 3 set must drive irq and assert carrier in loop-back");

   // the float control follows bit 3 in normal mode too
   chk_irq_float:
   assert property (!modem_control[MCL_MC_AUX_B] |=> !irq_oe_out)
      else $error("interrupt pin driven with bit 3 clear");

   // and the drive follows a set bit 3 in either mode
   chk_irq_drive:
   assert property (modem_control[MCL_MC_AUX_B] |=> irq_oe_out)
      else $error("interrupt pin floated with bit 3 set");

   // rts pin is the inverse of bit 1 in either mode
   chk_rts_drive:
   assert property (1'b1 |=> rts_n_out == !$past(modem_control[MCL_MC_RTS]))
      else $error("rts pin does not follow bit 1");

   // ---------------------------------------------------------------
   // events and interrupt line
   // ---------------------------------------------------------------
   // a looped rts change must reach the cts change bit; the loop entry cycle is
   // left out, since the pin level there may already match the new bit
   chk_loop_cts_evt:
   assert property (loop_on && $past(loop_on) && $changed(modem_control[MCL_MC_RTS]) ##1 loop_on
                    |=> ev.irq_status[MCL_MS_CTS])
      else $error("loop-back rts change did not raise the cts event");

   // receiver events set their sticky bit, even in a clear cycle
   chk_rx_sticky:
   assert property (rx_event_in |=> ev.irq_status[MCL_IRQ_RX])
      else $error("receiver event did not set its status bit");

   // transmitter events likewise
   chk_tx_sticky:
   assert property (tx_event_in |=> ev.irq_status[MCL_IRQ_TX])
      else $error("transmitter event did not set its status bit");

   // an enabled receiver event reaches the pin two cycles later
   chk_core_irq:
   assert property (rx_event_in && irq_enable_reg[MCL_IRQ_RX] ##1 irq_enable_reg[MCL_IRQ_RX] |=> irq_out)
      else $error("enabled receiver event did not reach the interrupt pin");

   // with every enable clear the pin stays low
   chk_irq_gate:
   assert property (irq_enable_reg == '0 ##1 irq_enable_reg == '0 |-> !irq_out)
      else $error("interrupt raised with all enables clear");

   // ---------------------------------------------------------------
   // coverage of the main scenarios
   // ---------------------------------------------------------------
   cov_loop_enter: cover property ($rose(loop_on));
   cov_loop_irq: cover property (loop_on && irq_oe_out && irq_out);
   cov_loop_dcd_evt: cover property (loop_on && ev.modem_evt[MCL_MS_DCD]);
   cov_norm_ring: cover property (!loop_on && ev.modem_evt[MCL_MS_RI]);
   cov_clear_race: cover property (ev.clr_stb && |(ev.clr_mask & {ev.core_evt, ev.modem_evt}));

endmodule
`default_nettype wire

/* mcl_modem_peer.sv */
// modem peer model: answers request-to-send with clear-to-send after a lag and
// drives the other modem lines and the serial line as the bench commands.
// assumes the same clock and reset as the block; pin levels are active low.
`timescale 1ns/1ps
`default_nettype none
module mcl_modem_peer #(
   parameter int LAG = 3
) (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic rts_n_in,
   input wire logic [2:0] lines_n_in,
   input wire logic rx_level_in,
   output logic cts_n_out,
   output logic dsr_n_out,
   output logic dcd_n_out,
   output logic ri_n_out,
   output logic rx_pin_out
);
   // -----------------------------------------------------------
   // handshake answer
   // -----------------------------------------------------------
   // a slow peer: clear-to-send trails the request by LAG clocks, never at once
   logic [LAG-1:0] rts_pipe;
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rts_pipe <= '1;
      end else begin
         rts_pipe <= {rts_pipe[LAG-2:0], rts_n_in};
      end
   end
   // flow control stays manual here; automatic mode is never asked of the control register
   assign cts_n_out = rts_pipe[LAG-1];
   assign {dsr_n_out, dcd_n_out, ri_n_out} = lines_n_in;
   assign rx_pin_out = rx_level_in;
endmodule
`default_nettype wire

/* modem_control_loopback_bench.sv */
// testbench for the modem control and loop-back block: apb register tasks,
// pin routing in both modes, core and modem interrupts, interrupt pin enable.
// assumes mcl_pkg, the design files and mcl_modem_peer are compiled first.
`timescale 1ns/1ps
`default_nettype none
module modem_control_loopback_bench;
   import mcl_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, tx_pin, rx_pin, rx_serial, rts_n, irq, irq_oe;
   logic tx_serial = 1'b1, peer_rx = 1'b1, rx_event = 1'b0, tx_event = 1'b0;
   logic cts_n, dsr_n, dcd_n, ri_n;
   logic [2:0] peer_lines_n = 3'h7;
   logic [3:0] modem_status;
   int mismatches = 0;
   int tests_run = 0;

   always #5 sys_clk = ~sys_clk;

   mcl_top dut_u (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .paddr_in(paddr), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .tx_serial_in(tx_serial), .tx_pin_out(tx_pin),
      .rx_pin_in(rx_pin), .rx_serial_out(rx_serial), .cts_n_in(cts_n), .dsr_n_in(dsr_n),
      .dcd_n_in(dcd_n), .ri_n_in(ri_n), .rts_n_out(rts_n), .modem_status_out(modem_status),
      .rx_event_in(rx_event), .tx_event_in(tx_event), .irq_out(irq), .irq_oe_out(irq_oe));

   mcl_modem_peer #(.LAG(3)) peer_u (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .rts_n_in(rts_n),
      .lines_n_in(peer_lines_n), .rx_level_in(peer_rx), .cts_n_out(cts_n), .dsr_n_out(dsr_n),
      .dcd_n_out(dcd_n), .ri_n_out(ri_n), .rx_pin_out(rx_pin));

   // -----------------------------------------------------------
   // report and compare
   // -----------------------------------------------------------
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // -----------------------------------------------------------
   // apb master: setup, access held until pready at a rising edge
   // -----------------------------------------------------------
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (!(pready === 1'b1) && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // a slave that never answers ends the run here
      if (pready !== 1'b1) begin
         mismatches++;
         tally_and_finish();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, rd, err);
   endtask

   task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0, rd, err);
      check(rd, exp);
   endtask

   // waits land a moment after the edge so registered outputs are settled
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic pulse_event(input logic is_tx);
      @(posedge sys_clk);
      if (is_tx) tx_event <= 1'b1;
      else rx_event <= 1'b1;
      @(posedge sys_clk);
      tx_event <= 1'b0;
      rx_event <= 1'b0;
   endtask

   // -----------------------------------------------------------
   // main sequence
   // -----------------------------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      settle(2);
      check(32'(rts_n), 32'h1);
      check(32'(irq_oe), 32'h0);
      rdck(MCL_OFF_MODEM_CTRL, 32'h0);
      tx_serial <= 1'b0;
      peer_rx <= 1'b0;
      settle(2);
      check(32'(tx_pin), 32'h0);
      check(32'(rx_serial), 32'h0);
      // request-to-send asserted; the peer answers with clear-to-send on the pin
      wr(MCL_OFF_MODEM_CTRL, 32'h02);
      settle(2);
      check(32'(rts_n), 32'h0);
      settle(6);
      check(32'(modem_status), 32'h1);
      wr(MCL_OFF_MODEM_CTRL, 32'h04);
      settle(8);
      check(32'(rts_n), 32'h1);
      check(32'(modem_status), 32'h0);
      @(posedge sys_clk);
      peer_lines_n <= 3'h6;
      settle(3);
      check(32'(modem_status), 32'h4);
      @(posedge sys_clk);
      peer_lines_n <= 3'h7;
      settle(3);
      // every low-bit pattern in loop-back; pins move against the expectation
      for (int v = 0; v < 16; v++) begin
         wr(MCL_OFF_MODEM_CTRL, 32'h10 | 32'(v));
         tx_serial <= v[0];
         peer_rx <= ~v[0];
         peer_lines_n <= 3'(~v);
         settle(3);
         check(32'(modem_status), 32'({v[3], v[2], v[0], v[1]}));
         check(32'(tx_pin), 32'h1);
         check(32'(rx_serial), 32'(v[0]));
         check(32'(irq_oe), 32'(v[3]));
         rdck(MCL_OFF_MODEM_STAT, 32'({v[3], v[2], v[0], v[1]}));
      end
      wr(MCL_OFF_IRQ_CLEAR, 32'h3f);
      rdck(MCL_OFF_IRQ_STATUS, 32'h0);
      // core interrupts keep working in loop-back, gated by the enables
      wr(MCL_OFF_IRQ_ENABLE, 32'h10);
      pulse_event(1'b0);
      settle(3);
      check(32'(irq), 32'h1);
      rdck(MCL_OFF_IRQ_STATUS, 32'h10);
      wr(MCL_OFF_IRQ_ENABLE, 32'h00);
      settle(3);
      check(32'(irq), 32'h0);
      pulse_event(1'b1);
      wr(MCL_OFF_IRQ_ENABLE, 32'h20);
      settle(3);
      check(32'(irq), 32'h1);
      wr(MCL_OFF_IRQ_CLEAR, 32'h30);
      settle(3);
      check(32'(irq), 32'h0);
      // modem event sourced from control bit 1 while looped back
      wr(MCL_OFF_IRQ_ENABLE, 32'h01);
      wr(MCL_OFF_MODEM_CTRL, 32'h1d);
      settle(4);
      check(32'(irq), 32'h1);
      rdck(MCL_OFF_IRQ_STATUS, 32'h01);
      wr(MCL_OFF_IRQ_CLEAR, 32'h01);
      wr(MCL_OFF_IRQ_STATUS, 32'h3f);
      rdck(MCL_OFF_IRQ_STATUS, 32'h0);
      // unmapped word: error response and zero data
      apb(8'h20, 1'b0, 32'h0, rd, err);
      check(32'(err), 32'h1);
      check(rd, 32'h0);
      // back to normal: pins reconnect
      wr(MCL_OFF_MODEM_CTRL, 32'h00);
      tx_serial <= 1'b0;
      peer_lines_n <= 3'h3;
      settle(4);
      check(32'(tx_pin), 32'h0);
      check(32'(modem_status), 32'h2);
      tally_and_finish();
   end
endmodule
`default_nettype wire
